// ### hw/pf_filter_monitor.sv
// Frame identifier filters with two flag outputs, and a read-only monitor bank.
// Assumes the stream, the demodulator status and the register port share this clock.
//
// How it works
// - First filter enabled and matching sets flag A.
// - First filter outranks second and masked third.
// - Second filter match without first sets flag B.
// - Third filter compares masked header bytes two-four.
// - All-zero mask disables the third filter.
// - Third skipped after earlier match; match sets both.
// - Reset clears all filter values, enables, mask.
// - Lock byte reports eight lock signals in order.
// - Corrected errors per window, uncorrectable frames excluded.
// - False sync words counted; rate is value/4096.
// - Uncorrectable frame count saturates at 255.
// - Timing offset shows raw integrator contents.
// - Downconversion offset in crystal over 2^20 units.
// - Carrier high-byte read latches coherent low byte.
// - Carrier offset signed, symbol rate over 2^17.
// - Noise high-byte read holds matching low byte.
// - Analog gain byte mirrors bounded PWM value.
// - Digital gain is mantissa and signed exponent.
// - Phase noise readable as two bytes.
`timescale 1ns/1ps
module pf_filter_monitor
  import pf_pkg::*;
#(
  parameter int WINDOW_BYTES = WINDOW_BITS / BITS_PER_BYTE,
  parameter int SYNC_WINDOW  = SYNC_CHECKS
)
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_ff,
  input  wire logic        ts_valid,
  input  wire logic        ts_sop,
  input  wire logic [7:0]  ts_byte,
  output logic             match_flag_a_ff,
  output logic             match_flag_b_ff,
  output logic             flags_new_ff,
  input  wire logic [7:0]  lock_in,
  input  wire logic        fec_byte_tick,
  input  wire logic        rs_frame_done,
  input  wire logic [7:0]  rs_err_count,
  input  wire logic        sync_check,
  input  wire logic        sync_false,
  input  wire logic [23:0] timing_integ,
  input  wire logic [15:0] dds_offset,
  input  wire logic [15:0] carrier_offset,
  input  wire logic [15:0] phase_noise_est,
  input  wire logic [15:0] add_noise_est,
  input  wire logic [7:0]  gain1_request,
  input  wire logic [7:0]  analog_gain_floor,
  input  wire logic [7:0]  analog_gain_ceiling,
  input  wire logic [10:0] gain2_mantissa,
  input  wire logic [4:0]  gain2_exponent,
  output logic             gain_pwm_ff
);
  localparam int BCW = $clog2(WINDOW_BYTES);
  localparam int SCW = $clog2(SYNC_WINDOW);

  logic [13:0]     first_filter_value_ff;
  logic [13:0]     second_filter_value_ff;
  logic [23:0]     third_filter_value_ff;
  logic [23:0]     third_filter_mask_ff;
  logic [1:0]      hdr_idx_ff;
  logic [15:0]     hdr_ff;
  logic [23:0]     hdr_word;
  logic            hdr_eval;
  logic [ID_W-1:0] frame_id;
  logic            hit1;
  logic            hit2;
  logic            hit3;
  logic [BCW-1:0]  byte_cnt_ff;
  logic            window_end;
  logic [23:0]     corr_acc_ff;
  logic [7:0]      unc_acc_ff;
  logic [23:0]     nxt_corr;
  logic [7:0]      nxt_unc;
  logic [24:0]     corr_sum;
  logic [23:0]     corrected_bit_errors_ff;
  logic [7:0]      uncorrectable_frames_ff;
  logic [SCW-1:0]  sync_cnt_ff;
  logic [7:0]      false_acc_ff;
  logic [7:0]      nxt_false;
  logic [7:0]      sync_word_error_rate_ff;
  logic [7:0]      analog_gain_level_ff;
  logic [7:0]      pwm_cnt_ff;
  logic [23:0]     cbe_snap;
  logic [23:0]     tim_snap;
  logic [15:0]     dds_snap;
  logic [15:0]     car_snap;
  logic [15:0]     phn_snap;
  logic [15:0]     noi_snap;
  logic [15:0]     gain2_snap;
  logic [15:0]     gain2_live;
  logic [7:0]      nxt_rdata;

  // Register writes; reset wins over a write in the same cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      first_filter_value_ff  <= FILT_RST;
      second_filter_value_ff <= FILT_RST;
      third_filter_value_ff  <= F3_RST;
      third_filter_mask_ff   <= F3_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADR_F1_HI: first_filter_value_ff[13:8]   <= reg_wdata[5:0];
        ADR_F1_LO: first_filter_value_ff[7:0]    <= reg_wdata;
        ADR_F2_HI: second_filter_value_ff[13:8]  <= reg_wdata[5:0];
        ADR_F2_LO: second_filter_value_ff[7:0]   <= reg_wdata;
        ADR_F3_V0: third_filter_value_ff[23:16]  <= reg_wdata;
        ADR_F3_V1: third_filter_value_ff[15:8]   <= reg_wdata;
        ADR_F3_V2: third_filter_value_ff[7:0]    <= reg_wdata;
        ADR_F3_M0: third_filter_mask_ff[23:16]   <= reg_wdata;
        ADR_F3_M1: third_filter_mask_ff[15:8]    <= reg_wdata;
        ADR_F3_M2: third_filter_mask_ff[7:0]     <= reg_wdata;
        default:   ;
      endcase
    end
  end

  // Header capture: byte one is the sync byte, bytes two to four are kept.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hdr_idx_ff <= 2'h0;
      hdr_ff     <= 16'h0000;
    end else if (ts_valid && ts_sop) begin
      hdr_idx_ff <= HDR_FIRST;
    end else if (ts_valid && (hdr_idx_ff != 2'h0)) begin
      hdr_ff     <= {hdr_ff[7:0], ts_byte};
      hdr_idx_ff <= (hdr_idx_ff == HDR_LAST) ? 2'h0 : hdr_idx_ff + 2'h1;
    end
  end

  assign hdr_eval = ts_valid && !ts_sop && (hdr_idx_ff == HDR_LAST);
  assign hdr_word = {hdr_ff, ts_byte};
  assign frame_id = {hdr_word[20:16], hdr_word[15:8]};

  pf_exact_match u_first (
    .enable   (first_filter_value_ff[FILT_EN_BIT+8]),
    .ref_id   (first_filter_value_ff[ID_W-1:0]),
    .frame_id (frame_id),
    .hit      (hit1)
  );

  pf_exact_match u_second (
    .enable   (second_filter_value_ff[FILT_EN_BIT+8]),
    .ref_id   (second_filter_value_ff[ID_W-1:0]),
    .frame_id (frame_id),
    .hit      (hit2)
  );

  // Masked compare; a zero mask would otherwise match every frame.
  assign hit3 = (third_filter_mask_ff != F3_RST) &&
                (((hdr_word ^ third_filter_value_ff) & third_filter_mask_ff) == F3_RST);

  // Flags change only on a completed header and hold between headers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      match_flag_a_ff <= 1'b0;
      match_flag_b_ff <= 1'b0;
      flags_new_ff    <= 1'b0;
    end else begin
      flags_new_ff <= hdr_eval;
      if (hdr_eval) begin
        if (hit1) begin
          match_flag_a_ff <= 1'b1;
          match_flag_b_ff <= 1'b0;
        end else if (hit2) begin
          match_flag_a_ff <= 1'b0;
          match_flag_b_ff <= 1'b1;
        end else if (hit3) begin
          match_flag_a_ff <= 1'b1;
          match_flag_b_ff <= 1'b1;
        end else begin
          match_flag_a_ff <= 1'b0;
          match_flag_b_ff <= 1'b0;
        end
      end
    end
  end

  // Bit window, counted in decoded bytes.
  assign window_end = fec_byte_tick && (byte_cnt_ff == BCW'(WINDOW_BYTES - 1));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_cnt_ff <= '0;
    end else if (window_end) begin
      byte_cnt_ff <= '0;
    end else if (fec_byte_tick) begin
      byte_cnt_ff <= byte_cnt_ff + BCW'(1);
    end
  end

  // Accumulators include the current event, so an event at the window edge is kept.
  always_comb begin
    corr_sum = {1'b0, corr_acc_ff} + {17'h00000, rs_err_count};
    nxt_corr = corr_acc_ff;
    nxt_unc  = unc_acc_ff;
    if (rs_frame_done) begin
      if (rs_err_count > UNCORR_MAX_ERR) begin
        nxt_unc = (unc_acc_ff == SAT_BYTE) ? SAT_BYTE : unc_acc_ff + 8'h01;
      end else begin
        nxt_corr = corr_sum[24] ? 24'hFFFFFF : corr_sum[23:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      corr_acc_ff             <= 24'h000000;
      unc_acc_ff              <= 8'h00;
      corrected_bit_errors_ff <= 24'h000000;
      uncorrectable_frames_ff <= 8'h00;
    end else if (window_end) begin
      corr_acc_ff             <= 24'h000000;
      unc_acc_ff              <= 8'h00;
      corrected_bit_errors_ff <= nxt_corr;
      uncorrectable_frames_ff <= nxt_unc;
    end else begin
      corr_acc_ff <= nxt_corr;
      unc_acc_ff  <= nxt_unc;
    end
  end

  // False sync words per fixed number of sync checks; software divides by that number.
  assign nxt_false = (sync_check && sync_false && (false_acc_ff != SAT_BYTE)) ?
                     false_acc_ff + 8'h01 : false_acc_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_cnt_ff             <= '0;
      false_acc_ff            <= 8'h00;
      sync_word_error_rate_ff <= 8'h00;
    end else if (sync_check) begin
      sync_cnt_ff <= sync_cnt_ff + SCW'(1);
      if (sync_cnt_ff == SCW'(SYNC_WINDOW - 1)) begin
        sync_word_error_rate_ff <= nxt_false;
        false_acc_ff            <= 8'h00;
      end else begin
        false_acc_ff <= nxt_false;
      end
    end
  end

  // Analog gain clamped into its configured range, then driven out as PWM.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      analog_gain_level_ff <= 8'h00;
    end else if (gain1_request < analog_gain_floor) begin
      analog_gain_level_ff <= analog_gain_floor;
    end else if (gain1_request > analog_gain_ceiling) begin
      analog_gain_level_ff <= analog_gain_ceiling;
    end else begin
      analog_gain_level_ff <= gain1_request;
    end
  end

  // A period of 255 steps makes 255 a steady high level.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwm_cnt_ff  <= 8'h00;
      gain_pwm_ff <= 1'b0;
    end else begin
      pwm_cnt_ff  <= (pwm_cnt_ff == PWM_TOP) ? 8'h00 : pwm_cnt_ff + 8'h01;
      gain_pwm_ff <= pwm_cnt_ff < analog_gain_level_ff;
    end
  end

  assign gain2_live = {gain2_mantissa, gain2_exponent};

  pf_snap #(.W(24)) u_cbe (
    .clock (clock), .sys_rst (sys_rst), .capture (reg_rd && (reg_addr == ADR_CBE0)),
    .live (corrected_bit_errors_ff), .held_ff (cbe_snap)
  );
  pf_snap #(.W(24)) u_tim (
    .clock (clock), .sys_rst (sys_rst), .capture (reg_rd && (reg_addr == ADR_TIM0)),
    .live (timing_integ), .held_ff (tim_snap)
  );
  pf_snap #(.W(16)) u_dds (
    .clock (clock), .sys_rst (sys_rst), .capture (reg_rd && (reg_addr == ADR_DDS0)),
    .live (dds_offset), .held_ff (dds_snap)
  );
  pf_snap #(.W(16)) u_car (
    .clock (clock), .sys_rst (sys_rst), .capture (reg_rd && (reg_addr == ADR_CAR0)),
    .live (carrier_offset), .held_ff (car_snap)
  );
  pf_snap #(.W(16)) u_phn (
    .clock (clock), .sys_rst (sys_rst), .capture (reg_rd && (reg_addr == ADR_PHN0)),
    .live (phase_noise_est), .held_ff (phn_snap)
  );
  pf_snap #(.W(16)) u_noi (
    .clock (clock), .sys_rst (sys_rst), .capture (reg_rd && (reg_addr == ADR_NOI0)),
    .live (add_noise_est), .held_ff (noi_snap)
  );
  pf_snap #(.W(16)) u_gain2 (
    .clock (clock), .sys_rst (sys_rst), .capture (reg_rd && (reg_addr == ADR_GAIN2_0)),
    .live (gain2_live), .held_ff (gain2_snap)
  );

  // First bytes come from the live value, later bytes from the frozen copy.
  // Noise and phase values are passed through unqualified by lock state.
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      ADR_F1_HI:   nxt_rdata = {2'b00, first_filter_value_ff[13:8]};
      ADR_F1_LO:   nxt_rdata = first_filter_value_ff[7:0];
      ADR_F2_HI:   nxt_rdata = {2'b00, second_filter_value_ff[13:8]};
      ADR_F2_LO:   nxt_rdata = second_filter_value_ff[7:0];
      ADR_F3_V0:   nxt_rdata = third_filter_value_ff[23:16];
      ADR_F3_V1:   nxt_rdata = third_filter_value_ff[15:8];
      ADR_F3_V2:   nxt_rdata = third_filter_value_ff[7:0];
      ADR_F3_M0:   nxt_rdata = third_filter_mask_ff[23:16];
      ADR_F3_M1:   nxt_rdata = third_filter_mask_ff[15:8];
      ADR_F3_M2:   nxt_rdata = third_filter_mask_ff[7:0];
      ADR_LOCK:    nxt_rdata = lock_in;
      ADR_CBE0:    nxt_rdata = corrected_bit_errors_ff[23:16];
      ADR_CBE1:    nxt_rdata = cbe_snap[15:8];
      ADR_CBE2:    nxt_rdata = cbe_snap[7:0];
      ADR_SYNCER:  nxt_rdata = sync_word_error_rate_ff;
      ADR_UNCORR:  nxt_rdata = uncorrectable_frames_ff;
      ADR_TIM0:    nxt_rdata = timing_integ[23:16];
      ADR_TIM1:    nxt_rdata = tim_snap[15:8];
      ADR_TIM2:    nxt_rdata = tim_snap[7:0];
      ADR_DDS0:    nxt_rdata = dds_offset[15:8];
      ADR_DDS1:    nxt_rdata = dds_snap[7:0];
      ADR_CAR0:    nxt_rdata = carrier_offset[15:8];
      ADR_CAR1:    nxt_rdata = car_snap[7:0];
      ADR_PHN0:    nxt_rdata = phase_noise_est[15:8];
      ADR_PHN1:    nxt_rdata = phn_snap[7:0];
      ADR_NOI0:    nxt_rdata = add_noise_est[15:8];
      ADR_NOI1:    nxt_rdata = noi_snap[7:0];
      ADR_GAIN1:   nxt_rdata = analog_gain_level_ff;
      ADR_GAIN2_0: nxt_rdata = gain2_live[15:8];
      ADR_GAIN2_1: nxt_rdata = gain2_snap[7:0];
      default:     nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_first_wins;
    hdr_eval && hit1 |=> match_flag_a_ff && !match_flag_b_ff;
  endproperty
  a_first_wins: assert property (p_first_wins) else $error("First filter match did not give flag A only.");

  property p_second;
    hdr_eval && hit2 && !hit1 |=> !match_flag_a_ff && match_flag_b_ff;
  endproperty
  a_second: assert property (p_second) else $error("Second filter match did not give flag B only.");

  property p_third;
    hdr_eval && !hit1 && !hit2 && (third_filter_mask_ff != F3_RST) &&
    (((hdr_word ^ third_filter_value_ff) & third_filter_mask_ff) == F3_RST)
    |=> match_flag_a_ff && match_flag_b_ff;
  endproperty
  a_third: assert property (p_third) else $error("Masked match did not set both flags.");

  property p_zero_mask;
    hdr_eval && !hit1 && !hit2 && (third_filter_mask_ff == F3_RST) |=> !match_flag_a_ff && !match_flag_b_ff;
  endproperty
  a_zero_mask: assert property (p_zero_mask) else $error("Zero mask still produced a match.");

  property p_hold;
    !hdr_eval |=> $stable(match_flag_a_ff) && $stable(match_flag_b_ff) && !flags_new_ff;
  endproperty
  a_hold: assert property (p_hold) else $error("Flags moved between headers.");

  property p_reset_clear;
    sys_rst |=> (first_filter_value_ff == FILT_RST) && (second_filter_value_ff == FILT_RST) &&
                             (third_filter_mask_ff == F3_RST) && (third_filter_value_ff == F3_RST);
  endproperty
  a_reset_clear: assert property (@(posedge clock) disable iff (1'b0) p_reset_clear)
    else $error("Filters not cleared by reset.");

  property p_lock_read;
    reg_rd && (reg_addr == ADR_LOCK) |=> reg_rdata_ff == $past(lock_in);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("Lock byte read wrong.");

  property p_unc_sat;
    (unc_acc_ff == SAT_BYTE) && !window_end |=> unc_acc_ff == SAT_BYTE;
  endproperty
  a_unc_sat: assert property (p_unc_sat) else $error("Uncorrectable count wrapped.");

  property p_car_coherent;
    reg_rd && (reg_addr == ADR_CAR0) ##1 !reg_rd ##1 (reg_rd && (reg_addr == ADR_CAR1))
    |=> reg_rdata_ff == $past(carrier_offset[7:0], 3);
  endproperty
  a_car_coherent: assert property (p_car_coherent) else $error("Carrier low byte not coherent.");

  property p_noise_coherent;
    reg_rd && (reg_addr == ADR_NOI0) ##1 !reg_rd ##1 (reg_rd && (reg_addr == ADR_NOI1))
    |=> reg_rdata_ff == $past(add_noise_est[7:0], 3);
  endproperty
  a_noise_coherent: assert property (p_noise_coherent) else $error("Noise low byte not coherent.");

  property p_gain_bound;
    analog_gain_floor <= analog_gain_ceiling |=>
      (analog_gain_level_ff >= $past(analog_gain_floor)) && (analog_gain_level_ff <= $past(analog_gain_ceiling));
  endproperty
  a_gain_bound: assert property (p_gain_bound) else $error("Analog gain outside its range.");

  c_first:  cover property (hdr_eval && hit1);
  c_third:  cover property (hdr_eval && hit3 && !hit1 && !hit2);
  c_window: cover property (window_end);
  c_car:    cover property (reg_rd && (reg_addr == ADR_CAR0) ##[1:8] reg_rd && (reg_addr == ADR_CAR1));
endmodule

// ### hw/pf_pkg.sv
// Shared constants of the frame filter and demodulator monitor bank.
// Assumes byte-wide register access at the printed byte addresses.
package pf_pkg;
  localparam logic [7:0] ADR_F1_HI   = 8'h70;
  localparam logic [7:0] ADR_F1_LO   = 8'h71;
  localparam logic [7:0] ADR_F2_HI   = 8'h72;
  localparam logic [7:0] ADR_F2_LO   = 8'h73;
  localparam logic [7:0] ADR_F3_V0   = 8'h74;
  localparam logic [7:0] ADR_F3_V1   = 8'h75;
  localparam logic [7:0] ADR_F3_V2   = 8'h76;
  localparam logic [7:0] ADR_F3_M0   = 8'h77;
  localparam logic [7:0] ADR_F3_M1   = 8'h78;
  localparam logic [7:0] ADR_F3_M2   = 8'h79;
  localparam logic [7:0] ADR_LOCK    = 8'h80;
  localparam logic [7:0] ADR_CBE0    = 8'h81;
  localparam logic [7:0] ADR_CBE1    = 8'h82;
  localparam logic [7:0] ADR_CBE2    = 8'h83;
  localparam logic [7:0] ADR_SYNCER  = 8'h84;
  localparam logic [7:0] ADR_UNCORR  = 8'h85;
  localparam logic [7:0] ADR_TIM0    = 8'h86;
  localparam logic [7:0] ADR_TIM1    = 8'h87;
  localparam logic [7:0] ADR_TIM2    = 8'h88;
  localparam logic [7:0] ADR_DDS0    = 8'h89;
  localparam logic [7:0] ADR_DDS1    = 8'h8A;
  localparam logic [7:0] ADR_CAR0    = 8'h8B;
  localparam logic [7:0] ADR_CAR1    = 8'h8C;
  localparam logic [7:0] ADR_PHN0    = 8'h8D;
  localparam logic [7:0] ADR_PHN1    = 8'h8E;
  localparam logic [7:0] ADR_NOI0    = 8'h8F;
  localparam logic [7:0] ADR_NOI1    = 8'h90;
  localparam logic [7:0] ADR_GAIN1   = 8'h91;
  localparam logic [7:0] ADR_GAIN2_0 = 8'h92;
  localparam logic [7:0] ADR_GAIN2_1 = 8'h93;
  localparam int         FILT_EN_BIT = 5;
  localparam int         ID_W        = 13;
  localparam logic [13:0] FILT_RST   = 14'h0000;
  localparam logic [23:0] F3_RST     = 24'h000000;
  localparam logic [7:0] UNCORR_MAX_ERR = 8'h08;
  localparam logic [7:0] SAT_BYTE    = 8'hFF;
  localparam logic [7:0] PWM_TOP     = 8'hFE;
  localparam logic [1:0] HDR_FIRST   = 2'h1;
  localparam logic [1:0] HDR_LAST    = 2'h3;
  localparam int         WINDOW_BITS = 100000000;
  localparam int         BITS_PER_BYTE = 8;
  localparam int         SYNC_CHECKS = 4096;
endpackage

// ### hw/pf_exact_match.sv
// Enabled exact comparison of a 13-bit frame identifier.
// Assumes the identifier and reference are stable in the evaluating cycle.
`timescale 1ns/1ps
module pf_exact_match
  import pf_pkg::*;
(
  input  wire logic            enable,
  input  wire logic [ID_W-1:0] ref_id,
  input  wire logic [ID_W-1:0] frame_id,
  output logic                 hit
);
  assign hit = enable && (ref_id == frame_id);
endmodule

// ### hw/pf_snap.sv
// Holds a multi-byte value frozen at the read of its first byte.
// Assumes the live value comes from logic on the same clock.
`timescale 1ns/1ps
module pf_snap
  import pf_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         capture,
  input  wire logic [W-1:0] live,
  output logic      [W-1:0] held_ff
);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      held_ff <= '0;
    end else if (capture) begin
      held_ff <= live;
    end
  end
endmodule

// ### bench/pf_demux_model.sv
// Downstream demultiplexer model that takes the flag pair on each new-header pulse.
// Assumes the flags and the pulse come from the filter block on the same clock.
`timescale 1ns/1ps
module pf_demux_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       flag_a,
  input  wire logic       flag_b,
  input  wire logic       flags_new,
  output logic      [1:0] taken_ff
);
  // Between headers the flags only hold, so the pulse alone says when to take them.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      taken_ff <= 2'h0;
    end else if (flags_new) begin
      taken_ff <= {flag_a, flag_b};
    end
  end
endmodule

// ### bench/tb_pf_filter_monitor.sv
// Self-checking bench for the frame filters and the monitor bank.
// Assumes the byte strobe register port and one 25 MHz clock.
`timescale 1ns/1ps
module tb_pf_filter_monitor;
  import pf_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, ts_byte = 8'h00, lock_in = 8'h00, rs_err_count = 8'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, ts_valid = 1'b0, ts_sop = 1'b0;
  logic        fec_byte_tick = 1'b0, rs_frame_done = 1'b0, sync_check = 1'b0, sync_false = 1'b0;
  logic [23:0] timing_integ = 24'hABCDEF;
  logic [15:0] dds_offset = 16'hBEEF, carrier_offset = 16'h1234;
  logic [15:0] phase_noise_est = 16'h4321, add_noise_est = 16'h8765;
  logic [7:0]  gain1_request = 8'hF0, analog_gain_floor = 8'h10, analog_gain_ceiling = 8'h80;
  logic [10:0] gain2_mantissa = 11'h5A5;
  logic [4:0]  gain2_exponent = 5'h13;
  logic [7:0]  reg_rdata_ff;
  logic        match_flag_a_ff, match_flag_b_ff, flags_new_ff, gain_pwm_ff;
  logic [1:0]  taken;
  int          error_cnt = 0, check_count = 0, cycles = 0, pwm_high = 0;

  pf_filter_monitor #(.WINDOW_BYTES(300), .SYNC_WINDOW(8)) dut (
    .clock, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_ff,
    .ts_valid, .ts_sop, .ts_byte, .match_flag_a_ff, .match_flag_b_ff, .flags_new_ff,
    .lock_in, .fec_byte_tick, .rs_frame_done, .rs_err_count, .sync_check, .sync_false,
    .timing_integ, .dds_offset, .carrier_offset, .phase_noise_est, .add_noise_est,
    .gain1_request, .analog_gain_floor, .analog_gain_ceiling, .gain2_mantissa,
    .gain2_exponent, .gain_pwm_ff);
  pf_demux_model partner (.clock(clock), .sys_rst(sys_rst), .flag_a(match_flag_a_ff),
    .flag_b(match_flag_b_ff), .flags_new(flags_new_ff), .taken_ff(taken));

  initial begin
    forever #20 clock = ~clock;
  end

  task automatic results();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The ceiling is several times the length of the full sequence.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), 24'(reg_rdata_ff), 24'(e));
  endtask

  // Sends sync byte and header bytes two to four, then checks flags and that they hold.
  task automatic frame(input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4, input logic [1:0] e);
    @(posedge clock);
    ts_valid <= 1'b1;
    ts_sop <= 1'b1;
    ts_byte <= 8'h47;
    @(posedge clock);
    ts_sop <= 1'b0;
    ts_byte <= b2;
    @(posedge clock);
    ts_byte <= b3;
    @(posedge clock);
    ts_byte <= b4;
    @(posedge clock);
    ts_valid <= 1'b0;
    #1 chk("flags", 24'({match_flag_a_ff, match_flag_b_ff, flags_new_ff}), 24'({e, 1'b1}));
    @(posedge clock);
    #1 chk("held", 24'({flags_new_ff, match_flag_a_ff, match_flag_b_ff, taken}), 24'({1'b0, e, e}));
  endtask

  task automatic ticks(input int n, input logic [7:0] err);
    repeat (n) begin
      @(posedge clock);
      fec_byte_tick <= 1'b1;
      rs_frame_done <= 1'b1;
      rs_err_count <= err;
    end
    @(posedge clock);
    fec_byte_tick <= 1'b0;
    rs_frame_done <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 'h70; a <= 'h79; a++) rd(8'(a), 8'h00);
    frame(8'h00, 8'h00, 8'h00, 2'h0);
    wr(ADR_F1_HI, 8'hE1);
    wr(ADR_F1_LO, 8'h23);
    wr(ADR_F2_HI, 8'h21);
    wr(ADR_F2_LO, 8'h23);
    rd(ADR_F1_HI, 8'h21);
    frame(8'hE1, 8'h23, 8'h00, 2'h2);
    wr(ADR_F2_LO, 8'h56);
    frame(8'h01, 8'h56, 8'h00, 2'h1);
    wr(ADR_F3_V2, 8'hAB);
    wr(ADR_F3_M2, 8'hFF);
    frame(8'h1F, 8'h00, 8'hAB, 2'h3);
    frame(8'h1F, 8'h00, 8'hAC, 2'h0);
    frame(8'h01, 8'h23, 8'hAB, 2'h2);
    frame(8'h01, 8'h56, 8'hAB, 2'h1);
    wr(ADR_F3_M2, 8'h00);
    frame(8'h1F, 8'h00, 8'hAB, 2'h0);
    wr(ADR_F1_HI, 8'h01);
    frame(8'h01, 8'h23, 8'h00, 2'h0);
    lock_in <= 8'hA5;
    wr(ADR_LOCK, 8'h00);
    rd(ADR_LOCK, 8'hA5);
    rd(8'h7F, 8'h00);
    rd(ADR_CAR0, 8'h12);
    carrier_offset <= 16'h5678;
    rd(ADR_CAR1, 8'h34);
    lock_in <= 8'hFF;
    rd(ADR_LOCK, 8'hFF);
    rd(ADR_NOI0, 8'h87);
    add_noise_est <= 16'h0000;
    rd(ADR_NOI1, 8'h65);
    rd(ADR_PHN0, 8'h43);
    rd(ADR_PHN1, 8'h21);
    rd(ADR_TIM0, 8'hAB);
    rd(ADR_TIM1, 8'hCD);
    rd(ADR_TIM2, 8'hEF);
    rd(ADR_DDS0, 8'hBE);
    rd(ADR_DDS1, 8'hEF);
    rd(ADR_GAIN1, 8'h80);
    gain1_request <= 8'h05;
    rd(ADR_GAIN1, 8'h10);
    // One full PWM period of 255 clocks must be high for exactly the level.
    repeat (255) begin
      @(posedge clock);
      #1 pwm_high += gain_pwm_ff;
    end
    chk("pwm", 24'(pwm_high), 24'h000010);
    rd(ADR_GAIN2_0, 8'hB4);
    rd(ADR_GAIN2_1, 8'hB3);
    ticks(300, 8'h09);
    rd(ADR_UNCORR, 8'hFF);
    rd(ADR_CBE0, 8'h00);
    rd(ADR_CBE2, 8'h00);
    ticks(300, 8'h01);
    rd(ADR_UNCORR, 8'h00);
    rd(ADR_CBE0, 8'h00);
    rd(ADR_CBE1, 8'h01);
    rd(ADR_CBE2, 8'h2C);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      sync_check <= 1'b1;
      sync_false <= (i < 3);
    end
    @(posedge clock);
    sync_check <= 1'b0;
    rd(ADR_SYNCER, 8'h03);
    results();
  end
endmodule
